// file: include/adcseq_consts.svh
// Purpose: constants for the converter data channel sequencer
// Assumes: accumulator bit 0 is the most significant bit (bus numbering)
// Notes:   macros only, no logic
`ifndef ADCSEQ_CONSTS_SVH
`define ADCSEQ_CONSTS_SVH
// ****************************************
// transfer selectors and function codes
// ****************************************
`define ADCSEQ_XFER_NONE   3'h0
`define ADCSEQ_XFER_OUT_A  3'h1
`define ADCSEQ_XFER_IN_A   3'h2
`define ADCSEQ_XFER_OUT_B  3'h3
`define ADCSEQ_XFER_IN_B   3'h4
`define ADCSEQ_XFER_OUT_C  3'h5
`define ADCSEQ_XFER_IN_C   3'h6
`define ADCSEQ_XFER_PULSE  3'h7
`define ADCSEQ_FN_NONE     2'h0
`define ADCSEQ_FN_START    2'h1
`define ADCSEQ_FN_CLEAR    2'h2
`define ADCSEQ_FN_PULSE    2'h3
// ****************************************
// widths and reset values
// ****************************************
`define ADCSEQ_CHAN_W      8
`define ADCSEQ_MUX_W       5
`define ADCSEQ_ADDR_W      15
`define ADCSEQ_COUNT_W     12
`define ADCSEQ_GAIN_W      2
`define ADCSEQ_DATA_W      16
`define ADCSEQ_CHAN_RST    8'h00
`define ADCSEQ_ADDR_RST    15'h0000
`define ADCSEQ_COUNT_RST   12'h000
`define ADCSEQ_GAIN_RST    2'h0
`endif

// file: include/adcseq_pkg.sv
// Purpose: types for the converter data channel sequencer
// Assumes: adcseq_consts.svh included first
// Notes:   types only
`include "adcseq_consts.svh"
package adcseq_pkg;
  typedef enum logic [2:0] {
    XF_NONE, XF_OUT_A, XF_IN_A, XF_OUT_B, XF_IN_B, XF_OUT_C, XF_IN_C, XF_PULSE
  } adcseq_xfer_type;
  typedef struct packed {
    logic [2:0]  xfer;
    logic [1:0]  func;
    logic [15:0] acc;
  } adcseq_cmd_type;
  typedef struct packed {
    logic [14:0] addr;
    logic [15:0] data;
  } adcseq_dch_type;
  typedef enum {
    SQ_IDLE, SQ_WAIT_PACE, SQ_CONVERT, SQ_TRANSFER
  } adcseq_state_type;
endpackage

// file: verilog/adcseq_chan_step.sv
// Purpose: next channel after a conversion
// Assumes: combinational, used by the sequencer
// Notes:   full eight bits take part in the compare
`timescale 1ns/100ps
`include "adcseq_consts.svh"
module adcseq_chan_step #(
  parameter int CHAN_W = `ADCSEQ_CHAN_W
) (
  input  wire logic [CHAN_W-1:0] cur,
  input  wire logic [CHAN_W-1:0] limit,
  input  wire logic              auto_adv,
  output logic      [CHAN_W-1:0] nxt
);
  logic [CHAN_W-1:0] inc;
  assign inc = cur + {{(CHAN_W-1){1'b0}}, 1'b1};
  always_comb begin
    if (cur >= limit) begin
      nxt = '0;
    end else if (auto_adv) begin
      nxt = (inc > limit) ? '0 : inc;
    end else begin
      nxt = cur;
    end
  end
endmodule

// file: verilog/adcseq_result_reg.sv
// Purpose: holds the converter word for the memory write
// Assumes: write strobe from the sequencer
// Notes:   registered read data
`timescale 1ns/100ps
module adcseq_result_reg #(
  parameter int DATA_W = 16
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic      [DATA_W-1:0] rd_data
);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else if (wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule

// file: verilog/adcseq_sequencer.sv
// Contract
// - eight-bit limit beside eight-bit channel
// - after limit channel conversion, channel clears
// - auto advance increments, clears above limit
// - advance disabled: channel never increments
// - disabled, channel at/above limit clears once
// - five bits drive mux, eight compare
// - single-channel build ignores channel registers
// - clear command zeroes busy and done
// - pulse sets busy, clears done
// - no pacing clock: pulse starts immediately
// - pacing: each conversion waits next tick
// - each conversion end requests memory write
// - sequence end: busy off, done, interrupt
// - fifteen-bit destination address counter
// - address increments after each transfer
// - address readable anytime, one past last
// - twelve-bit negated conversion count
// - count increments with address, zero ends
// - gain loads with every count load
// - limit from bits 0-7, channel 8-15
// - every transfer applies its function field, but pulse ignores clear
// - gain codes select x1 x2 x4 x8
// - gain bits 0-1, count bits 4-15
// - address uses bits 1-15, bit 0 zero
//
// Purpose: extended converter controller running data channel sequences
// Assumes: bus bit 0 is the msb; converter answers start with conv_done
// Notes:   analog converter itself stays outside
`timescale 1ns/100ps
`include "adcseq_consts.svh"
module adcseq_sequencer #(
  parameter bit MULTI_CHAN = 1'b1,
  parameter bit GAIN_FITTED = 1'b1,
  parameter int CHAN_W = `ADCSEQ_CHAN_W,
  parameter int ADDR_W = `ADCSEQ_ADDR_W,
  parameter int COUNT_W = `ADCSEQ_COUNT_W
) (
  input  wire logic                      clock,
  input  wire logic                      arst_n,
  input  wire adcseq_pkg::adcseq_cmd_type cmd,
  output logic [15:0]                    rd_data,
  output logic                           busy,
  output logic                           done,
  output logic                           irq_req,
  input  wire logic                      auto_adv,
  input  wire logic                      pace_en,
  input  wire logic                      pace_tick,
  output logic                           conv_start,
  input  wire logic                      conv_done,
  input  wire logic [15:0]               conv_data,
  output logic [`ADCSEQ_MUX_W-1:0]       mux_sel,
  output logic [`ADCSEQ_GAIN_W-1:0]      gain_code,
  output logic [3:0]                     gain_factor,
  output logic                           dch_req,
  output adcseq_pkg::adcseq_dch_type     dch,
  input  wire logic                      dch_ack
);
  // ****************************************
  // registers
  // ****************************************
  logic [CHAN_W-1:0]  limit_channel_ff;
  logic [CHAN_W-1:0]  current_channel_ff;
  logic [ADDR_W-1:0]  destination_address_counter_ff;
  logic [COUNT_W-1:0] conversion_count_ff;
  logic [1:0]         amplifier_gain_ff;
  logic               busy_ff;
  logic               done_ff;
  logic               irq_ff;
  logic [15:0]        rd_data_ff;
  adcseq_pkg::adcseq_state_type state_ff;
  adcseq_pkg::adcseq_state_type nxt_state;
  logic [CHAN_W-1:0]  nxt_channel;
  logic [15:0]        result_word;
  logic               result_wr;
  logic               cmd_start;
  logic               cmd_clear;
  logic               seq_end;
  logic               xfer_fire;
  logic               ld_chan;
  logic               ld_addr;
  logic               ld_count;
  logic [3:0]         gain_factor_ff;

  // ****************************************
  // strobes and sequence end
  // ****************************************
  assign xfer_fire = dch_req && dch_ack;
  // the last ack is the one that carries the count from all ones to zero
  assign seq_end   = xfer_fire && (conversion_count_ff == {{(COUNT_W-1){1'b1}}, 1'b1});
  assign cmd_start = (cmd.func == `ADCSEQ_FN_START) || (cmd.func == `ADCSEQ_FN_PULSE)
                     || (cmd.xfer == `ADCSEQ_XFER_PULSE);
  assign cmd_clear = (cmd.func == `ADCSEQ_FN_CLEAR) && (cmd.xfer != `ADCSEQ_XFER_PULSE);

  // ****************************************
  // load strobes, one per output transfer
  // ****************************************
  always_comb begin
    ld_chan  = 1'b0;
    ld_addr  = 1'b0;
    ld_count = 1'b0;
    case (cmd.xfer)
      `ADCSEQ_XFER_OUT_A: ld_chan  = 1'b1;
      `ADCSEQ_XFER_OUT_B: ld_addr  = 1'b1;
      `ADCSEQ_XFER_OUT_C: ld_count = 1'b1;
      default:            ld_count = 1'b0;
    endcase
  end

  adcseq_chan_step #(
    .CHAN_W (CHAN_W)
  ) u_step (
    .cur      (current_channel_ff),
    .limit    (limit_channel_ff),
    .auto_adv (auto_adv),
    .nxt      (nxt_channel)
  );

  adcseq_result_reg #(
    .DATA_W (16)
  ) u_result (
    .clock   (clock),
    .arst_n  (arst_n),
    .wr_en   (result_wr),
    .wr_data (conv_data),
    .rd_data (result_word)
  );

  // ****************************************
  // register loads
  // ****************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      limit_channel_ff   <= `ADCSEQ_CHAN_RST;
      current_channel_ff <= `ADCSEQ_CHAN_RST;
    end else if (ld_chan) begin
      limit_channel_ff   <= cmd.acc[15:8];
      current_channel_ff <= cmd.acc[7:0];
    end else if (MULTI_CHAN && conv_done && state_ff == adcseq_pkg::SQ_CONVERT) begin
      current_channel_ff <= nxt_channel;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      destination_address_counter_ff <= `ADCSEQ_ADDR_RST;
    end else if (ld_addr) begin
      destination_address_counter_ff <= cmd.acc[14:0];
    end else if (xfer_fire) begin
      destination_address_counter_ff <= destination_address_counter_ff + ADDR_W'(1);
    end
  end

  // loading a count always loads the gain when fitted; otherwise the gain keeps its reset value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      conversion_count_ff <= `ADCSEQ_COUNT_RST;
      amplifier_gain_ff   <= `ADCSEQ_GAIN_RST;
    end else if (ld_count) begin
      conversion_count_ff <= cmd.acc[11:0];
      if (GAIN_FITTED) begin
        amplifier_gain_ff <= cmd.acc[15:14];
      end
    end else if (xfer_fire) begin
      conversion_count_ff <= conversion_count_ff + COUNT_W'(1);
    end
  end

  // factor kept in a flop so the amplifier never sees a decode glitch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gain_factor_ff <= 4'h1;
    end else if (GAIN_FITTED && ld_count) begin
      case (cmd.acc[15:14])
        2'h0:    gain_factor_ff <= 4'h1;
        2'h1:    gain_factor_ff <= 4'h2;
        2'h2:    gain_factor_ff <= 4'h4;
        default: gain_factor_ff <= 4'h8;
      endcase
    end
  end

  // ****************************************
  // read path, registered
  // ****************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= 16'h0000;
    end else begin
      // reads never touch the counters, so a mid-run read is harmless
      case (cmd.xfer)
        `ADCSEQ_XFER_IN_A: rd_data_ff <= {limit_channel_ff, current_channel_ff};
        `ADCSEQ_XFER_IN_B: rd_data_ff <= {1'b0, destination_address_counter_ff};
        `ADCSEQ_XFER_IN_C: rd_data_ff <= result_word;
        default:           rd_data_ff <= rd_data_ff;
      endcase
    end
  end

  // ****************************************
  // sequence state machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      adcseq_pkg::SQ_IDLE: begin
        if (cmd_start) begin
          nxt_state = pace_en ? adcseq_pkg::SQ_WAIT_PACE : adcseq_pkg::SQ_CONVERT;
        end
      end
      adcseq_pkg::SQ_WAIT_PACE: begin
        if (pace_tick) begin
          nxt_state = adcseq_pkg::SQ_CONVERT;
        end
      end
      adcseq_pkg::SQ_CONVERT: begin
        if (conv_done) begin
          nxt_state = adcseq_pkg::SQ_TRANSFER;
        end
      end
      adcseq_pkg::SQ_TRANSFER: begin
        if (seq_end) begin
          nxt_state = adcseq_pkg::SQ_IDLE;
        end else if (xfer_fire) begin
          nxt_state = pace_en ? adcseq_pkg::SQ_WAIT_PACE : adcseq_pkg::SQ_CONVERT;
        end
      end
      default: nxt_state = adcseq_pkg::SQ_IDLE;
    endcase
    // clear aborts; a late start re-enters wait or convert directly
    if (cmd_clear) begin
      nxt_state = adcseq_pkg::SQ_IDLE;
    // a start on the final ack is dropped, so the flags and state agree
    end else if (cmd_start && !seq_end && state_ff != adcseq_pkg::SQ_IDLE) begin
      nxt_state = pace_en ? adcseq_pkg::SQ_WAIT_PACE : adcseq_pkg::SQ_CONVERT;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= adcseq_pkg::SQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      conv_start <= 1'b0;
    end else begin
      // one pulse per conversion, never held across a stay in convert
      conv_start <= (nxt_state == adcseq_pkg::SQ_CONVERT)
                    && (state_ff != adcseq_pkg::SQ_CONVERT);
    end
  end

  // result captured as the request rises, so data holds while it waits
  assign result_wr = (state_ff == adcseq_pkg::SQ_CONVERT) && conv_done;

  // ****************************************
  // flags; sequence end beats a same-cycle clear
  // ****************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end else if (seq_end) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b1;
      irq_ff  <= 1'b1;
    end else if (cmd_start) begin
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end else if (cmd_clear) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dch_req     = (state_ff == adcseq_pkg::SQ_TRANSFER);
  assign dch.addr    = destination_address_counter_ff;
  assign dch.data    = result_word;
  assign mux_sel     = MULTI_CHAN ? current_channel_ff[`ADCSEQ_MUX_W-1:0]
                                  : {`ADCSEQ_MUX_W{1'b0}};
  assign gain_code   = GAIN_FITTED ? amplifier_gain_ff : 2'h0;
  assign gain_factor = gain_factor_ff;
  assign rd_data     = rd_data_ff;
  assign busy        = busy_ff;
  assign done        = done_ff;
  assign irq_req     = irq_ff;
endmodule

// file: verification/adcseq_sva.sv
// Purpose: port checks for adcseq_sequencer
// Assumes: one clock domain, reset async low
// Notes:   bound from the bench top file
`timescale 1ns/100ps
module adcseq_sva (
  input wire logic                       clock,
  input wire logic                       arst_n,
  input wire adcseq_pkg::adcseq_cmd_type cmd,
  input wire logic                       busy,
  input wire logic                       done,
  input wire logic                       irq_req,
  input wire logic                       pace_en,
  input wire logic                       pace_tick,
  input wire logic                       conv_start,
  input wire logic                       conv_done,
  input wire logic [15:0]                conv_data,
  input wire logic [1:0]                 gain_code,
  input wire logic [3:0]                 gain_factor,
  input wire logic                       dch_req,
  input wire adcseq_pkg::adcseq_dch_type dch,
  input wire logic                       dch_ack
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // ****
  // checks
  // ****
  // sequence end beats clear, so the final ack cycle is left out
  clear_flags_a: assert property (
    cmd.func == 2'h2 && !(dch_req && dch_ack) |=> !busy && !done && !irq_req)
    else $error("clear left a flag set");
  pulse_arm_a: assert property (
    cmd.func == 2'h3 && !(dch_req && dch_ack) |=> busy && !done)
    else $error("pulse did not arm");
  start_now_a: assert property (
    (cmd.func == 2'h1 || cmd.func == 2'h3) && !pace_en && !busy |=> conv_start)
    else $error("start without pacing was late");
  pace_wait_a: assert property (
    pace_en && conv_start |-> $past(pace_tick))
    else $error("paced start without a tick");
  conv_req_a: assert property (
    conv_done && busy && !dch_req |=> dch_req && dch.data == $past(conv_data))
    else $error("result not requested");
  req_hold_a: assert property (
    dch_req && !dch_ack && cmd.func == 2'h0 |=> dch_req && $stable(dch))
    else $error("request dropped before ack");
  gain_map_a: assert property (
    gain_factor == ((gain_code == 2'h0) ? 4'h1 : (gain_code == 2'h1) ? 4'h2 :
                    (gain_code == 2'h2) ? 4'h4 : 4'h8))
    else $error("gain factor wrong");
  gain_load_a: assert property (
    cmd.xfer == 3'h5 |=> gain_code == $past(cmd.acc[15:14]))
    else $error("gain not loaded");
endmodule

// file: verification/adcseq_partner.sv
// Purpose: converter and memory port model
// Assumes: slow selects long waits on both sides
// Notes:   data line toggles between results
`timescale 1ns/100ps
module adcseq_partner (
  input  wire logic   clock,
  input  wire logic   arst_n,
  input  wire logic   slow,
  input  wire logic   conv_start,
  output logic        conv_done,
  output logic [15:0] conv_data,
  input  wire logic   dch_req,
  output logic        dch_ack
);
  logic [3:0]  conv_wait_ff;
  logic        conv_busy_ff;
  logic [15:0] sample_ff;
  logic [2:0]  ack_wait_ff;
  // ****
  // converter and memory port
  // ****
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      conv_busy_ff <= 1'h0;
      conv_wait_ff <= 4'h0;
      conv_done    <= 1'h0;
      conv_data    <= 16'h0000;
      sample_ff    <= 16'h8421;
    end else begin
      conv_done <= 1'h0;
      conv_data <= ~conv_data; // no stale word outside the result cycle
      if (conv_start) begin
        conv_busy_ff <= 1'h1;
        conv_wait_ff <= slow ? 4'h7 : 4'h1;
      end else if (conv_busy_ff && conv_wait_ff != 4'h0) begin
        conv_wait_ff <= conv_wait_ff - 4'h1;
      end else if (conv_busy_ff) begin
        conv_busy_ff <= 1'h0;
        conv_done    <= 1'h1;
        conv_data    <= sample_ff;
        sample_ff    <= sample_ff + 16'h0F0F;
      end
    end
  end
  // ack only once req is seen, so a request that drops early is caught
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dch_ack     <= 1'h0;
      ack_wait_ff <= 3'h0;
    end else begin
      dch_ack <= 1'h0;
      if (!dch_req || dch_ack) begin
        ack_wait_ff <= slow ? 3'h5 : 3'h0;
      end else if (ack_wait_ff != 3'h0) begin
        ack_wait_ff <= ack_wait_ff - 3'h1;
      end else begin
        dch_ack <= 1'h1;
      end
    end
  end
endmodule

// file: verification/adcseq_sequencer_tb.sv
// Purpose: self-checking bench for adcseq_sequencer
// Assumes: partner model answers converter and memory
// Notes:   fixed corner runs, then random runs
`timescale 1ns/100ps
`include "adcseq_consts.svh"
module adcseq_sequencer_tb;
  adcseq_pkg::adcseq_cmd_type cmd;
  adcseq_pkg::adcseq_dch_type dch;
  logic [15:0] rd_data, conv_data;
  logic [4:0]  mux_sel;
  logic [3:0]  gain_factor;
  logic [1:0]  gain_code;
  logic        clock, arst_n, busy, done, irq_req, auto_adv, pace_en, pace_tick;
  logic        conv_start, conv_done, dch_req, dch_ack, slow, exp_auto;
  logic [7:0]  exp_chan, exp_lim;
  logic [14:0] exp_addr;
  logic [15:0] last_res;
  logic [31:0] rnd;
  int          acks, snap, tick_cnt, runs, fails, compares, seed;
  adcseq_sequencer u_adcseq_sequencer (.clock, .arst_n, .cmd, .rd_data, .busy, .done,
    .irq_req, .auto_adv, .pace_en, .pace_tick, .conv_start, .conv_done, .conv_data,
    .mux_sel, .gain_code, .gain_factor, .dch_req, .dch, .dch_ack);
  adcseq_partner u_adcseq_partner (.clock, .arst_n, .slow, .conv_start, .conv_done,
    .conv_data, .dch_req, .dch_ack);
  // ****
  // helpers
  // ****
  always #5 clock = ~clock;
  function automatic logic [7:0] step_chan(input logic [7:0] cur);
    if (cur >= exp_lim) return 8'h00;
    return exp_auto ? cur + 8'h01 : cur;
  endfunction
  function automatic logic [3:0] gain_exp(input logic [1:0] c);
    case (c)
      2'h0: return 4'h1;
      2'h1: return 4'h2;
      2'h2: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic issue(input logic [2:0] x, input logic [1:0] f, input logic [15:0] a);
    @(negedge clock);
    snap = acks;
    cmd = {x, f, a};
    @(negedge clock);
    cmd = '0;
  endtask
  always @(negedge clock) begin
    tick_cnt = tick_cnt + 1;
    pace_tick = (tick_cnt % 11 == 0);
  end
  always @(posedge clock) begin
    if (arst_n && conv_done) last_res = conv_data;
    if (arst_n && conv_start) begin
      chk({11'h000, mux_sel}, {11'h000, exp_chan[4:0]});
      exp_chan = step_chan(exp_chan);
    end
    if (arst_n && dch_req && dch_ack) begin
      chk({1'h0, dch.addr}, {1'h0, exp_addr});
      chk(dch.data, last_res);
      exp_addr = exp_addr + 15'h0001;
      acks = acks + 1;
    end
  end
  // ****
  // one sequence: load, pulse or start, read mid-run, wait, read back, clear
  // ****
  task automatic run(input logic [7:0] ch, input logic [7:0] lim, input logic [12:0] n,
                     input logic au, input logic pc);
    logic [15:0] r;
    logic [14:0] a0;
    logic [1:0]  g;
    logic [1:0]  f;
    r = 16'($random(seed));
    a0 = 15'($random(seed));
    g = 2'(runs);
    runs++;
    f = (runs % 3 == 1) ? `ADCSEQ_FN_PULSE : `ADCSEQ_FN_NONE;
    auto_adv = au;
    pace_en = pc;
    slow = r[0] && n < 13'h0100; // long runs kept fast for run time
    exp_chan = ch;
    exp_lim = lim;
    exp_auto = au;
    exp_addr = a0;
    acks = 0;
    issue(`ADCSEQ_XFER_OUT_A, `ADCSEQ_FN_NONE, {lim, ch});
    issue(`ADCSEQ_XFER_OUT_B, `ADCSEQ_FN_NONE, {r[15], a0});
    issue(`ADCSEQ_XFER_OUT_C, f, {g, r[13:12], 12'h000 - n[11:0]});
    if (runs % 3 == 2) issue(`ADCSEQ_XFER_PULSE, `ADCSEQ_FN_NONE, 16'h0000);
    if (runs % 3 == 0) issue(`ADCSEQ_XFER_NONE, `ADCSEQ_FN_START, 16'h0000);
    chk({14'h0000, gain_code}, {14'h0000, g});
    chk({12'h000, gain_factor}, {12'h000, gain_exp(g)});
    chk({14'h0000, busy, done}, 16'h0002);
    issue(`ADCSEQ_XFER_IN_B, `ADCSEQ_FN_NONE, 16'h0000);
    chk(rd_data, {1'h0, a0 + 15'(snap)});
    for (int k = 0; k < 70000 && done !== 1'h1; k++) @(negedge clock);
    chk(16'(acks), {3'h0, n});
    chk({13'h0000, busy, done, irq_req}, 16'h0003);
    issue(`ADCSEQ_XFER_IN_C, `ADCSEQ_FN_NONE, 16'h0000);
    chk(rd_data, last_res);
    issue(`ADCSEQ_XFER_IN_B, `ADCSEQ_FN_NONE, 16'h0000);
    chk(rd_data, {1'h0, a0 + 15'(n)});
    issue(`ADCSEQ_XFER_IN_A, `ADCSEQ_FN_CLEAR, 16'h0000);
    chk(rd_data, {lim, exp_chan});
    chk({13'h0000, busy, done, irq_req}, 16'h0000);
  endtask
  initial begin
    seed = 32'h16178540;
    {clock, arst_n, auto_adv, pace_en, pace_tick, slow} = 6'h00;
    cmd = '0;
    {fails, compares, tick_cnt, acks, runs} = '0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    arst_n = 1'h1;
    run(8'h05, 8'h07, 13'h0006, 1'h1, 1'h0);
    run(8'h09, 8'h03, 13'h0004, 1'h0, 1'h1);
    run(8'h02, 8'h06, 13'h0003, 1'h0, 1'h0);
    run(8'h21, 8'h03, 13'h0006, 1'h1, 1'h1);
    run(8'h00, 8'h1F, 13'h1000, 1'h1, 1'h0);
    for (int i = 0; i < 12; i++) begin
      rnd = $random(seed);
      run(rnd[7:0], rnd[15:8], 13'(rnd[18:16]) + 13'h0001, rnd[20], rnd[21]);
    end
    test_done;
  end
  initial begin
    repeat (95000) @(posedge clock);
    fails++;
    test_done;
  end
endmodule
bind adcseq_sequencer adcseq_sva u_adcseq_sva (.clock, .arst_n, .cmd, .busy, .done,
  .irq_req, .pace_en, .pace_tick, .conv_start, .conv_done, .conv_data, .gain_code,
  .gain_factor, .dch_req, .dch, .dch_ack);
